// ===== rtl/bnm_pkg.sv
// package: pin timing and geometry for the bytewide nv memory host port
package bnm_pkg;
	localparam int CLK_PERIOD_NS = 50;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 32768;
	localparam int ROW_BYTES = 8;
	localparam int ROW_BITS = 64;
	localparam int ROW_ADDR_LSB = 3;
	localparam int ACCESS_TIME_NS = 70;
	localparam int PRECHARGE_MIN_TIME_NS = 60;
	localparam int DATA_SETUP_NS = 30;
	localparam int CE_LOW_MAX_NS = 10000;
	localparam int ACCESS_CYC = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRECHARGE_CYC =
		(PRECHARGE_MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETUP_CYC = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// one stage short of the sync depth, so the byte sampled at select rise is taken
	localparam int CAPTURE_CYC = 1;
	localparam int CE_LOW_MAX_CYC = CE_LOW_MAX_NS / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	typedef enum logic [2:0] {
		BNM_IDLE,
		BNM_SETUP,
		BNM_ACCESS,
		BNM_CAPTURE,
		BNM_PRECHARGE
	} bnm_state_t;
endpackage : bnm_pkg

// ===== rtl/bnm_timer.sv
// file: down counter that paces each phase of a memory cycle
`timescale 1ns/1ns
module bnm_timer
	import bnm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_load,
	input wire logic [CNT_W-1:0] i_count,
	output logic o_done
);
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_reg <= 4'h0;
		end else if (i_load) begin
			cnt_reg <= i_count;
		end else if (cnt_reg != 4'h0) begin
			cnt_reg <= cnt_reg - 4'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_done <= 1'b0;
		end else begin
			o_done <= !i_load && (cnt_reg <= 4'h1);
		end
	end
endmodule : bnm_timer

// ===== rtl/bnm_host.sv
// file: host controller that drives the bytewide nv memory pins
// ----------------------------------------------------------------
// Behaviour
// R1: every access opens with chip select falling
// R2: 15-bit address selects one of 32768 bytes
// R3: device latches address at chip select fall
// R4: device finishes cycle even if deselected early
// R5: device drives data only after access time
// R6: output strobe high keeps data lines undriven
// R7: write low at select fall means write
// R8: late write fall turns read into write
// R9: write ends at first rising strobe edge
// R10: hold strobes low access time, data setup
// R11: writes finish in cycle, no polling
// R12: chip select high precharge minimum before next
// R13: chip select low never beyond maximum limit
// R14: each access wears one whole 8-byte row
// R15: strobe chip select for every access
// R16: hold chip select high while supply low; host checks supply before starting an access, and mid-access gates only the write strobe with it
// R17: power cycling keeps write strobe high
// R18: read and write cycles are equally long
// ----------------------------------------------------------------
`timescale 1ns/1ns
module bnm_host
	import bnm_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_power_good,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic [DATA_W-1:0] i_data_lines,
	output logic o_ready,
	output logic o_done,
	output logic [DATA_W-1:0] o_rdata,
	output logic [ROW_ADDR_LSB-1:0] o_unused,
	output logic o_chip_sel_b,
	output logic o_write_b,
	output logic o_out_en_b,
	output logic [ADDR_W-1:0] o_addr_lines,
	output logic [DATA_W-1:0] o_data_lines,
	output logic o_data_lines_oe
);
	bnm_state_t state_reg;
	logic [DATA_W-1:0] din_meta_reg;
	logic [DATA_W-1:0] din_sync_reg;
	logic pg_meta_reg;
	logic pg_sync_reg;
	logic we_reg;
	logic load;
	logic [CNT_W-1:0] load_cnt;
	logic tmr_done;
	logic [7:0] low_cnt_reg;
	localparam int DONE_LAT = CAPTURE_CYC + PRECHARGE_CYC + 2;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			din_meta_reg <= 8'h00;
			din_sync_reg <= 8'h00;
			pg_meta_reg <= 1'b0;
			pg_sync_reg <= 1'b0;
		end else begin
			din_meta_reg <= i_data_lines;
			din_sync_reg <= din_meta_reg;
			pg_meta_reg <= i_power_good;
			pg_sync_reg <= pg_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// phase timer
	// ----------------------------------------------------------------
	// read byte is sampled on the last select-low edge; capture waits out the sync stages
	always_comb begin
		load = 1'b0;
		load_cnt = 4'h0;
		case (state_reg)
			BNM_IDLE: begin
				load = i_req && pg_sync_reg;
				load_cnt = CNT_W'(SETUP_CYC);
			end
			BNM_SETUP: begin
				load = tmr_done;
				load_cnt = CNT_W'(ACCESS_CYC); // R10 R18
			end
			BNM_ACCESS: begin
				load = tmr_done;
				load_cnt = CNT_W'(CAPTURE_CYC);
			end
			BNM_CAPTURE: begin
				load = tmr_done;
				load_cnt = CNT_W'(PRECHARGE_CYC); // R12
			end
			default: begin
				load = 1'b0;
				load_cnt = 4'h0;
			end
		endcase
	end

	bnm_timer u_timer (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_load(load),
		.i_count(load_cnt),
		.o_done(tmr_done)
	);

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= BNM_IDLE;
		end else begin
			case (state_reg)
				BNM_IDLE: if (load) state_reg <= BNM_SETUP; // R16
				BNM_SETUP: if (tmr_done) state_reg <= BNM_ACCESS; // R1 R15
				BNM_ACCESS: if (tmr_done) state_reg <= BNM_CAPTURE;
				BNM_CAPTURE: if (tmr_done) state_reg <= BNM_PRECHARGE;
				BNM_PRECHARGE: if (tmr_done) state_reg <= BNM_IDLE; // R11
				default: state_reg <= BNM_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// request capture; address held whole cycle though device latches it
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			we_reg <= 1'b0;
			o_addr_lines <= 15'h0000;
			o_data_lines <= 8'h00;
			o_unused <= 3'h0;
		end else if (state_reg == BNM_IDLE && load) begin
			we_reg <= i_we;
			o_addr_lines <= i_addr; // R2 R3
			o_data_lines <= i_wdata;
			o_unused <= i_addr[ROW_ADDR_LSB-1:0]; // R14
		end
	end

	// ----------------------------------------------------------------
	// pin strobes
	// ----------------------------------------------------------------
	// write strobe falls with select (select-controlled write) and rises with it
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_chip_sel_b <= 1'b1;
			o_write_b <= 1'b1;
			o_out_en_b <= 1'b1;
			o_data_lines_oe <= 1'b0;
		end else begin
			o_chip_sel_b <= !(state_reg == BNM_ACCESS && !tmr_done); // R1 R12 R13
			o_write_b <= !(we_reg && state_reg == BNM_ACCESS && !tmr_done
				&& pg_sync_reg); // R7 R9 R17
			o_out_en_b <= !(!we_reg && state_reg == BNM_ACCESS && !tmr_done); // R5 R6
			o_data_lines_oe <= we_reg && (state_reg == BNM_SETUP
				|| state_reg == BNM_ACCESS); // R10
		end
	end

	// ----------------------------------------------------------------
	// user answer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rdata <= 8'h00;
			o_done <= 1'b0;
			o_ready <= 1'b0;
		end else begin
			o_done <= state_reg == BNM_PRECHARGE && tmr_done;
			o_ready <= state_reg == BNM_IDLE && !load && pg_sync_reg;
			if (state_reg == BNM_CAPTURE && tmr_done && !we_reg) begin
				o_rdata <= din_sync_reg; // R5
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_cnt_reg <= 8'h00;
		end else if (o_chip_sel_b) begin
			low_cnt_reg <= 8'h00;
		end else begin
			low_cnt_reg <= low_cnt_reg + 8'h01;
		end
	end

	sequence s_sel_rise;
		!$past(o_chip_sel_b) && o_chip_sel_b;
	endsequence

	a_precharge_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R12
		s_sel_rise |-> o_chip_sel_b [*2]) else $error("precharge too short");
	a_low_limit: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R13
		low_cnt_reg <= 8'(CE_LOW_MAX_CYC)) else $error("select low too long");
	a_low_min: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R10
		$fell(o_chip_sel_b) |-> !o_chip_sel_b [*2]) else $error("access too short");
	a_write_in_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R7
		!o_write_b |-> !o_chip_sel_b && o_out_en_b) else $error("write outside select");
	a_write_data: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R10
		!o_write_b |-> o_data_lines_oe && $stable(o_data_lines))
		else $error("write data not driven");
	a_no_contend: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R6
		!(o_data_lines_oe && !o_out_en_b)) else $error("bus contention");
	a_addr_stable: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R3
		!o_chip_sel_b |-> $stable(o_addr_lines)) else $error("address moved");
	a_power_block: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R16
		(state_reg == BNM_IDLE && !pg_sync_reg) |=> state_reg == BNM_IDLE && o_chip_sel_b)
		else $error("access while power low");
	a_done_after: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R11
		s_sel_rise |-> ##[DONE_LAT:DONE_LAT] o_done) else $error("done missing");
	a_read_drive: assert property (@(posedge i_clk) disable iff (!i_rst_b) // R6
		!o_out_en_b |-> !o_chip_sel_b && !o_data_lines_oe) else $error("read strobe stray");
endmodule : bnm_host

// ===== verification/bnm_mem_model.sv
// partner model of the bytewide nv memory device
`timescale 1ns/1ns
module bnm_mem_model
	import bnm_pkg::*;
(
	input wire logic i_chip_sel_b,
	input wire logic i_write_b,
	input wire logic i_out_en_b,
	input wire logic [ADDR_W-1:0] i_addr_lines,
	input wire logic [DATA_W-1:0] i_data_lines,
	output logic [DATA_W-1:0] o_data_lines,
	output logic o_data_lines_oe,
	output int o_viol
);
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	int wear [MEM_DEPTH/ROW_BYTES];
	logic [ADDR_W-1:0] lat = '0;
	logic wr = 1'b0;
	logic valid = 1'b0;
	wire [DATA_W-1:0] d_dly;
	time fall_t = 0;
	time rise_t = 0;
	time dchg_t = 0;
	// delayed copy so a release in the strobe's own step is not stored
	assign #1 d_dly = i_data_lines;
	always @(d_dly) dchg_t = $time;
	initial o_viol = 0;
	always @(negedge i_chip_sel_b) begin
		if (rise_t != 0 && $time - rise_t < PRECHARGE_MIN_TIME_NS) o_viol++;
		lat = i_addr_lines;
		wear[lat >> ROW_ADDR_LSB]++;
		wr = !i_write_b;
		valid = 1'b0;
		fall_t = $time;
		valid <= #(ACCESS_TIME_NS) 1'b1;
	end
	always @(negedge i_write_b) if (!i_chip_sel_b) wr = 1'b1;
	always @(posedge i_write_b or posedge i_chip_sel_b) begin
		if (wr) begin
			if ($time - fall_t < ACCESS_TIME_NS) o_viol++;
			if ($time - dchg_t < DATA_SETUP_NS) o_viol++;
			mem[lat] = d_dly;
			wr = 1'b0;
		end
	end
	always @(posedge i_chip_sel_b) begin
		if ($time - fall_t > CE_LOW_MAX_NS) o_viol++;
		rise_t = $time;
	end
	assign o_data_lines_oe = !i_chip_sel_b && !i_out_en_b && valid && !wr;
	assign o_data_lines = mem[lat];
endmodule : bnm_mem_model

// ===== verification/tb_bytewide_nv_memory_port.sv
// self-checking bench for the bytewide nv memory host port
`timescale 1ns/1ns
module tb_bytewide_nv_memory_port;
	import bnm_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_b = 1'b0;
	logic i_power_good = 1'b1;
	logic i_req = 1'b0;
	logic i_we = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic [DATA_W-1:0] junk = 8'h5a;
	logic [DATA_W-1:0] exp_mem [int];
	int mismatches = 0;
	int check_count = 0;
	int viol;
	logic o_ready, o_done, o_chip_sel_b, o_write_b, o_out_en_b, o_data_lines_oe, mem_oe;
	logic [DATA_W-1:0] o_rdata, o_data_lines, mem_d;
	logic [ADDR_W-1:0] o_addr_lines, a;
	// no pull on the bus: a released bus shows a toggling pattern
	wire [DATA_W-1:0] bus = o_data_lines_oe ? o_data_lines : mem_oe ? mem_d : junk;
	always #(CLK_PERIOD_NS/2) i_clk = ~i_clk;
	always @(posedge i_clk) junk <= ~junk;
	bnm_host i_dut (.i_clk, .i_rst_b, .i_power_good, .i_req, .i_we, .i_addr, .i_wdata,
		.i_data_lines(bus), .o_ready, .o_done, .o_rdata, .o_unused(), .o_chip_sel_b,
		.o_write_b, .o_out_en_b, .o_addr_lines, .o_data_lines, .o_data_lines_oe);
	bnm_mem_model i_mem (.i_chip_sel_b(o_chip_sel_b), .i_write_b(o_write_b),
		.i_out_en_b(o_out_en_b), .i_addr_lines(o_addr_lines), .i_data_lines(bus),
		.o_data_lines(mem_d), .o_data_lines_oe(mem_oe), .o_viol(viol));
	// ----------
	// checking
	// ----------
	task automatic check_byte(string n, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : check_byte
	task automatic check_flag(string n, logic e, logic g);
		check_byte(n, {7'h00, e}, {7'h00, g});
	endtask : check_flag
	// a phase of n timer cycles spans n+1 edges
	function automatic int exp_latency();
		return SETUP_CYC + ACCESS_CYC + CAPTURE_CYC + PRECHARGE_CYC + 4;
	endfunction : exp_latency
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_of_test
	always @(posedge i_clk) if (o_data_lines_oe === 1'b1 && mem_oe === 1'b1)
		check_flag("bus_clash", 1'b0, 1'b1);
	task automatic access(logic we, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] d);
		int n;
		n = 0;
		while (o_ready !== 1'b1 && n < 20) begin
			@(posedge i_clk);
			#1 n++;
		end
		check_flag("ready", 1'b1, o_ready);
		i_req = 1'b1;
		i_we = we;
		i_addr = ad;
		i_wdata = d;
		@(posedge i_clk);
		#1 i_req = 1'b0;
		i_addr = ADDR_W'($urandom);
		i_wdata = DATA_W'($urandom);
		n = 0;
		while (o_done !== 1'b1 && n < 20) begin
			@(posedge i_clk);
			#1 n++;
		end
		check_byte("done_latency", DATA_W'(exp_latency()), DATA_W'(n));
		if (we) exp_mem[ad] = d;
		else check_byte("read_data", exp_mem[ad], o_rdata);
	endtask : access
	initial begin
		void'($urandom(32'hd2a80cc2));
		repeat (10) @(posedge i_clk);
		#1 i_rst_b = 1'b1;
		access(1'b1, '0, 8'h00);
		access(1'b1, 15'h7fff, 8'hff);
		access(1'b0, '0, 8'h00);
		for (int k = 0; k < 16; k++) begin
			a = ADDR_W'($urandom);
			access(1'b1, a, DATA_W'($urandom));
			access(1'b0, a, 8'h00);
		end
		// host reset in mid-run; the memory keeps its contents
		i_rst_b = 1'b0;
		repeat (3) @(posedge i_clk);
		#1 check_flag("rst_sel", 1'b1, o_chip_sel_b);
		check_flag("rst_ready", 1'b0, o_ready);
		i_rst_b = 1'b1;
		i_power_good = 1'b0;
		repeat (4) @(posedge i_clk);
		#1 i_req = 1'b1;
		repeat (10) begin
			@(posedge i_clk);
			#1 check_flag("sel_idle", 1'b1, o_chip_sel_b);
			check_flag("wr_idle", 1'b1, o_write_b);
		end
		i_req = 1'b0;
		i_power_good = 1'b1;
		access(1'b0, 15'h7fff, 8'h00);
		check_flag("protocol_ok", 1'b1, viol == 0);
		end_of_test();
	end
	initial begin
		#(4000 * CLK_PERIOD_NS);
		mismatches++;
		end_of_test();
	end
endmodule : tb_bytewide_nv_memory_port
